//--- cue_solo_scene_pkg.sv
// shared constants, types and a bus decode function for the cue, solo and scene control block
`default_nettype none

package cue_solo_scene_pkg;

  // channel and bus counts
  localparam int NUM_INPUT = 24;
  localparam int NUM_VCA = 8;
  localparam int NUM_MASTER = 25;
  localparam int NUM_ON = NUM_INPUT + NUM_MASTER;
  localparam int NUM_FEED = NUM_INPUT + NUM_VCA + NUM_MASTER;

  // master bus layout: groups, stereo, matrix, aux
  localparam int GROUP_BASE = 0;
  localparam int STEREO_IDX = 8;
  localparam int MATRIX_BASE = 9;
  localparam int AUX_BASE = 17;

  // solo select switch positions
  localparam int NUM_SEL = 4;
  localparam int SEL_MATRIX = 0;
  localparam int SEL_AUX = 1;
  localparam int SEL_GROUP = 2;
  localparam int SEL_STEREO = 3;

  // scene memory
  localparam int SCENE_COUNT = 128;
  localparam int ADDR_BITS = 7;
  localparam int DIRECT_COUNT = 8;
  localparam logic [7:0] SCENE_FIRST = 8'h01;
  localparam logic [7:0] SCENE_LAST = 8'h80;
  localparam logic [7:0] ENTRY_MAX = 8'hFF;
  localparam logic [11:0] ENTRY_RADIX = 12'h00A;
  localparam logic [1:0] RECALL_IDLE = 2'h0;
  localparam logic [1:0] RECALL_READ = 2'h1;
  localparam logic [1:0] RECALL_LOAD = 2'h2;

  // timing at the 20 MHz system clock
  localparam int CLOCK_HZ = 20_000_000;
  localparam int FLASH_HALF_MS = 250;
  localparam int HOLD_MS = 1000;
  localparam int FLASH_CYCLES_DEFAULT = CLOCK_HZ / 1000 * FLASH_HALF_MS;
  localparam int HOLD_CYCLES_DEFAULT = CLOCK_HZ / 1000 * HOLD_MS;
  localparam int CNT_BITS = 25;

  // listen groups, gray coded
  typedef enum logic [1:0] {
    GRP_MASTER = 2'h0,
    GRP_VCA = 2'h1,
    GRP_INPUT = 2'h3
  } listen_group_type;

  // utility cycle, gray coded along the key-press order
  typedef enum logic [3:0] {
    UTIL_OFF = 4'h0,
    UTIL_BATTERY = 4'h1,
    UTIL_MEM_PROTECT = 4'h3,
    UTIL_SOLO_PROTECT = 4'h2,
    UTIL_STEREO_CUE = 4'h6,
    UTIL_INIT = 4'h7,
    UTIL_CHANNEL = 4'h5,
    UTIL_PROGRAM = 4'h4,
    UTIL_CONTROL = 4'hC,
    UTIL_OMNI = 4'hD,
    UTIL_ECHO = 4'hF,
    UTIL_DUMP = 4'hE,
    UTIL_REQUEST = 4'hA
  } util_mode_type;

  // what the display is showing
  typedef enum logic [1:0] {
    DISP_SCENE = 2'h0,
    DISP_ENTRY = 2'h1,
    DISP_UTIL = 2'h3,
    DISP_PARAM = 2'h2
  } display_kind_type;

  // which solo select switch governs a master bus
  function automatic int busKind(input int idx);
    if (idx == STEREO_IDX)
      return SEL_STEREO;
    else if (idx >= AUX_BASE)
      return SEL_AUX;
    else if (idx >= MATRIX_BASE)
      return SEL_MATRIX;
    else
      return SEL_GROUP;
  endfunction

endpackage

`default_nettype wire

//--- cue_latch.sv
// electronically latching cue switches for one listen group
`default_nettype none

module cue_latch
  import cue_solo_scene_pkg::*;
#(
  parameter int WIDTH = 1
)(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clkEnable,
  // key presses and control
  input wire logic [WIDTH-1:0] press,
  input wire logic clearAll,
  input wire logic latestOnly,
  input wire logic foreignPress,
  // state
  output logic [WIDTH-1:0] latched,
  output logic anyNew
);

  logic [WIDTH-1:0] next_latched; // latch value for the next edge
  logic [WIDTH-1:0] lowestPress; // single winner when keys coincide

  // toggle on press, or keep only the latest source
  always_comb
  begin
    lowestPress = press & (~press + WIDTH'(1));
    anyNew = !clearAll && |(press & ~latched);
    next_latched = latched;
    if (clearAll)
      next_latched = '0;
    else if (latestOnly && (|press || foreignPress))
      next_latched = lowestPress;
    else
      next_latched = latched ^ press;
  end

  // register only
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      latched <= '0;
    else if (clkEnable)
      latched <= next_latched;
  end

endmodule

`default_nettype wire

//--- scene_store.sv
// scene memory holding channel on settings
`default_nettype none

module scene_store
  import cue_solo_scene_pkg::*;
(
  // clock
  input wire logic sys_clk,
  input wire logic clkEnable,
  // access
  input wire logic [ADDR_BITS-1:0] addr,
  input wire logic writeEn,
  input wire logic [NUM_ON-1:0] writeData,
  output logic [NUM_ON-1:0] readData
);

  // contents are not cleared by reset, like the battery-backed original
  logic [NUM_ON-1:0] scenes [SCENE_COUNT];

  // synchronous write and read
  always_ff @(posedge sys_clk)
  begin
    if (clkEnable)
    begin
      if (writeEn)
        scenes[addr] <= writeData;
      readData <= scenes[addr];
    end
  end

endmodule

`default_nettype wire

//--- cue_solo_scene_control.sv
// cue priority, solo and scene memory key handling for the control panel
// How it works
// - input cue makes input group active
// - last input cue released restores previous group
// - solo cue mutes others, solo lamp flashes
// - normal mode cues add to headphones, no mutes
// - four latching bus solo selects, solo only
// - selected bus on state follows its cue
// - master prefader listen taps before fader
// - vca prepan listen taps before pan
// - engaging latest-only clears all cues
// - latest-only keeps only newest cue source
// - disengaging latest-only clears all cues
// - utility key steps modes, ending off
// - one second utility hold exits utility
// - recall applies displayed scene
// - display shows scene, entry, utility or parameter
// - store writes on settings; toggles parameter view in utility
// - check mode previews scene on check lamps
// - digits plus enter set scene; up/down step
// - direct keys recall scenes one to eight
// - matrix cue joins master group or replaces
// - 128 scenes; on keys edit settings
// - groups exclusive; new source switches group
// - cue keys toggle an electronic latch
`default_nettype none

module cue_solo_scene_control
  import cue_solo_scene_pkg::*;
#(
  parameter int FLASH_CYCLES = FLASH_CYCLES_DEFAULT,
  parameter int HOLD_CYCLES = HOLD_CYCLES_DEFAULT
)(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clkEnable,
  // cue keys, one-cycle presses
  input wire logic [NUM_INPUT-1:0] inputCuePress,
  input wire logic [NUM_VCA-1:0] vcaCuePress,
  input wire logic [NUM_MASTER-1:0] masterCuePress,
  // solo section switches
  input wire logic soloMode,
  input wire logic [NUM_SEL-1:0] soloSelPress,
  input wire logic master_prefader_listen,
  input wire logic vca_prepan_listen,
  input wire logic lastCueSwitch,
  // scene keys
  input wire logic utilityKey,
  input wire logic recallKey,
  input wire logic storeKey,
  input wire logic checkKey,
  input wire logic enterKey,
  input wire logic upKey,
  input wire logic downKey,
  input wire logic digitPress,
  input wire logic [3:0] digitValue,
  input wire logic [DIRECT_COUNT-1:0] directRecallKey,
  input wire logic [NUM_ON-1:0] onEditPress,
  // cue and solo results
  output logic [NUM_INPUT-1:0] inputCueLamp,
  output logic [NUM_VCA-1:0] vcaCueLamp,
  output logic [NUM_MASTER-1:0] masterCueLamp,
  output var listen_group_type listenGroup,
  output logic [NUM_FEED-1:0] cueFeed,
  output logic [NUM_INPUT-1:0] inputMute,
  output logic soloLamp,
  output logic [NUM_SEL-1:0] soloSelLamp,
  output logic masterTapPreFader,
  output logic vcaTapPrePan,
  // scene results
  output logic [NUM_ON-1:0] channelOnLamp,
  output logic checkModeLamp,
  output logic [NUM_ON-1:0] checkLamp,
  output logic utilityLamp,
  output var display_kind_type displayKind,
  output logic [7:0] displayValue
);

  // cue latch wiring
  logic inNew, vcaNew, masterNew; // a key newly engaged a source
  logic lastCuePrev; // previous latest-only switch level
  logic lastCueEdge; // latest-only switch changed
  logic [NUM_ON-1:0] readData; // scene memory output
  logic memWrite; // store strobe to memory

  // group and solo state
  listen_group_type prevGroup, next_listenGroup, next_prevGroup;
  logic [NUM_SEL-1:0] next_soloSel;
  logic [CNT_BITS-1:0] flashCount, next_flashCount;
  logic flashPhase, next_flashPhase;

  // utility and scene state
  util_mode_type utilMode, next_utilMode;
  logic [CNT_BITS-1:0] holdCount, next_holdCount;
  logic utilKeyPrev, utilAccess, next_utilAccess;
  logic [7:0] utilParam, next_utilParam;
  logic [7:0] sceneNumber, next_sceneNumber;
  logic [7:0] entryValue, next_entryValue;
  logic entryActive, next_entryActive;
  logic next_checkMode;
  logic [1:0] recallStage, next_recallStage;
  logic [NUM_ON-1:0] onState, next_onState;
  logic [11:0] entryProduct; // widened for digit accumulation

  // registered outputs computed from next state
  logic [NUM_FEED-1:0] next_cueFeed;
  logic [NUM_INPUT-1:0] next_inputMute;
  logic [NUM_ON-1:0] next_channelOnLamp;
  display_kind_type next_displayKind;
  logic [7:0] next_displayValue;

  // either edge of latest-only clears every latch
  assign lastCueEdge = lastCueSwitch != lastCuePrev;

  // one latch bank per listen group; presses in other banks displace in latest-only mode
  cue_latch #(.WIDTH(NUM_INPUT)) inputBank (
    .sys_clk(sys_clk), .reset(reset), .clkEnable(clkEnable),
    .press(inputCuePress), .clearAll(lastCueEdge), .latestOnly(lastCueSwitch),
    .foreignPress(|vcaCuePress || |masterCuePress),
    .latched(inputCueLamp), .anyNew(inNew)
  );
  cue_latch #(.WIDTH(NUM_VCA)) vcaBank (
    .sys_clk(sys_clk), .reset(reset), .clkEnable(clkEnable),
    .press(vcaCuePress), .clearAll(lastCueEdge), .latestOnly(lastCueSwitch),
    .foreignPress(|inputCuePress || |masterCuePress),
    .latched(vcaCueLamp), .anyNew(vcaNew)
  );
  cue_latch #(.WIDTH(NUM_MASTER)) masterBank (
    .sys_clk(sys_clk), .reset(reset), .clkEnable(clkEnable),
    .press(masterCuePress), .clearAll(lastCueEdge), .latestOnly(lastCueSwitch),
    .foreignPress(|inputCuePress || |vcaCuePress),
    .latched(masterCueLamp), .anyNew(masterNew)
  );

  // scene memory addressed by the displayed scene number
  scene_store memory (
    .sys_clk(sys_clk), .clkEnable(clkEnable),
    .addr(ADDR_BITS'(sceneNumber - SCENE_FIRST)), .writeEn(memWrite),
    .writeData(onState), .readData(readData)
  );

  // step through the utility modes in panel order
  function automatic util_mode_type nextUtility(input util_mode_type mode);
    unique case (mode)
      UTIL_OFF: return UTIL_BATTERY;
      UTIL_BATTERY: return UTIL_MEM_PROTECT;
      UTIL_MEM_PROTECT: return UTIL_SOLO_PROTECT;
      UTIL_SOLO_PROTECT: return UTIL_STEREO_CUE;
      UTIL_STEREO_CUE: return UTIL_INIT;
      UTIL_INIT: return UTIL_CHANNEL;
      UTIL_CHANNEL: return UTIL_PROGRAM;
      UTIL_PROGRAM: return UTIL_CONTROL;
      UTIL_CONTROL: return UTIL_OMNI;
      UTIL_OMNI: return UTIL_ECHO;
      UTIL_ECHO: return UTIL_DUMP;
      UTIL_DUMP: return UTIL_REQUEST;
      UTIL_REQUEST: return UTIL_OFF;
      default: return UTIL_OFF; // unused codes fall back to off
    endcase
  endfunction

  // next values for state and registered outputs, except edge trackers, taps and the solo, check and utility lamps
  always_comb
  begin
    next_listenGroup = listenGroup;
    next_prevGroup = prevGroup;
    next_soloSel = soloSelLamp ^ soloSelPress;
    next_flashCount = flashCount;
    next_flashPhase = flashPhase;
    next_utilMode = utilMode;
    next_holdCount = holdCount;
    next_utilAccess = utilAccess;
    next_utilParam = utilParam;
    next_sceneNumber = sceneNumber;
    next_entryValue = entryValue;
    next_entryActive = entryActive;
    next_checkMode = checkModeLamp;
    next_recallStage = RECALL_IDLE;
    next_onState = onState ^ onEditPress;
    memWrite = 1'b0;
    entryProduct = {4'h0, entryValue} * ENTRY_RADIX + {8'h00, digitValue};

    // listen group priority: input beats vca beats master
    if (inNew)
    begin
      if (listenGroup != GRP_INPUT)
        next_prevGroup = listenGroup;
      next_listenGroup = GRP_INPUT;
    end
    else if (vcaNew)
      next_listenGroup = GRP_VCA;
    else if (masterNew)
      next_listenGroup = GRP_MASTER;
    else if (listenGroup == GRP_INPUT && inputCueLamp == '0)
      next_listenGroup = prevGroup;

    // solo lamp blink timer, restarted lit whenever solo is entered
    if (!soloMode)
    begin
      next_flashCount = '0;
      next_flashPhase = 1'b1;
    end
    else if (flashCount == CNT_BITS'(FLASH_CYCLES - 1))
    begin
      next_flashCount = '0;
      next_flashPhase = !flashPhase;
    end
    else
      next_flashCount = flashCount + CNT_BITS'(1);

    // utility key acts on release so a long hold can mean exit
    if (utilityKey && holdCount != CNT_BITS'(HOLD_CYCLES))
      next_holdCount = holdCount + CNT_BITS'(1);
    if (utilKeyPrev && !utilityKey)
    begin
      next_holdCount = '0;
      next_utilAccess = 1'b0;
      if (utilMode != UTIL_OFF && holdCount == CNT_BITS'(HOLD_CYCLES))
        next_utilMode = UTIL_OFF;
      else
        next_utilMode = nextUtility(utilMode);
    end

    // scene keys; a recall in progress finishes first
    if (recallStage == RECALL_READ)
      next_recallStage = RECALL_LOAD;
    else if (recallStage == RECALL_LOAD)
      next_onState = readData;
    else if (|directRecallKey)
    begin
      for (int i = DIRECT_COUNT - 1; i >= 0; i--)
        if (directRecallKey[i])
          next_sceneNumber = SCENE_FIRST + 8'(i);
      next_entryActive = 1'b0;
      next_recallStage = RECALL_READ;
    end
    else if (recallKey)
      next_recallStage = RECALL_READ;
    else if (storeKey)
    begin
      if (utilMode != UTIL_OFF)
        next_utilAccess = !utilAccess;
      else
        memWrite = 1'b1;
    end
    else if (checkKey)
      next_checkMode = !checkModeLamp;
    else if (digitPress)
    begin
      next_entryActive = 1'b1;
      if (!entryActive)
        next_entryValue = {4'h0, digitValue};
      else if (entryProduct > {4'h0, ENTRY_MAX})
        next_entryValue = ENTRY_MAX;
      else
        next_entryValue = entryProduct[7:0];
    end
    else if (enterKey && entryActive)
    begin
      next_entryActive = 1'b0;
      if (entryValue >= SCENE_FIRST && entryValue <= SCENE_LAST)
        next_sceneNumber = entryValue;
      // any other value is dropped
    end
    else if (upKey || downKey)
    begin
      if (utilAccess)
        next_utilParam = upKey ? utilParam + 8'h01 : utilParam - 8'h01;
      else if (entryActive)
        next_entryValue = upKey ? entryValue + 8'h01 : entryValue - 8'h01;
      else if (upKey && sceneNumber != SCENE_LAST)
        next_sceneNumber = sceneNumber + 8'h01;
      else if (downKey && sceneNumber != SCENE_FIRST)
        next_sceneNumber = sceneNumber - 8'h01;
    end

    // headphone feed: only the active group, only in cue mode
    next_cueFeed = '0;
    if (!soloMode)
    begin
      if (next_listenGroup == GRP_INPUT)
        next_cueFeed[NUM_INPUT-1:0] = inputCueLamp;
      else if (next_listenGroup == GRP_VCA)
        next_cueFeed[NUM_INPUT+NUM_VCA-1:NUM_INPUT] = vcaCueLamp;
      else
        next_cueFeed[NUM_FEED-1:NUM_INPUT+NUM_VCA] = masterCueLamp;
    end

    // solo in place mutes every uncued input while at least one input is cued
    next_inputMute = (soloMode && |inputCueLamp) ? ~inputCueLamp : '0;

    // on lamps: stored settings, overridden by soloed busses
    next_channelOnLamp = next_onState;
    for (int j = 0; j < NUM_MASTER; j++)
      if (soloMode && next_soloSel[busKind(j)])
        next_channelOnLamp[NUM_INPUT+j] = masterCueLamp[j];

    // display source
    if (next_utilMode != UTIL_OFF)
    begin
      next_displayKind = next_utilAccess ? DISP_PARAM : DISP_UTIL;
      next_displayValue = next_utilAccess ? next_utilParam : {4'h0, next_utilMode};
    end
    else if (next_entryActive)
    begin
      next_displayKind = DISP_ENTRY;
      next_displayValue = next_entryValue;
    end
    else
    begin
      next_displayKind = DISP_SCENE;
      next_displayValue = next_sceneNumber;
    end
  end

  // register only; check lamps follow the memory word of the shown scene
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      listenGroup <= GRP_MASTER;
      prevGroup <= GRP_MASTER;
      soloSelLamp <= '0;
      flashCount <= '0;
      flashPhase <= 1'b1;
      lastCuePrev <= 1'b0;
      utilMode <= UTIL_OFF;
      holdCount <= '0;
      utilKeyPrev <= 1'b0;
      utilAccess <= 1'b0;
      utilParam <= 8'h00;
      sceneNumber <= SCENE_FIRST;
      entryValue <= 8'h00;
      entryActive <= 1'b0;
      checkModeLamp <= 1'b0;
      recallStage <= RECALL_IDLE;
      onState <= '0;
      cueFeed <= '0;
      inputMute <= '0;
      soloLamp <= 1'b0;
      masterTapPreFader <= 1'b0;
      vcaTapPrePan <= 1'b0;
      channelOnLamp <= '0;
      checkLamp <= '0;
      utilityLamp <= 1'b0;
      displayKind <= DISP_SCENE;
      displayValue <= SCENE_FIRST;
    end
    else if (clkEnable)
    begin
      listenGroup <= next_listenGroup;
      prevGroup <= next_prevGroup;
      soloSelLamp <= next_soloSel;
      flashCount <= next_flashCount;
      flashPhase <= next_flashPhase;
      lastCuePrev <= lastCueSwitch;
      utilMode <= next_utilMode;
      holdCount <= next_holdCount;
      utilKeyPrev <= utilityKey;
      utilAccess <= next_utilAccess;
      utilParam <= next_utilParam;
      sceneNumber <= next_sceneNumber;
      entryValue <= next_entryValue;
      entryActive <= next_entryActive;
      checkModeLamp <= next_checkMode;
      recallStage <= next_recallStage;
      onState <= next_onState;
      cueFeed <= next_cueFeed;
      inputMute <= next_inputMute;
      soloLamp <= soloMode && next_flashPhase;
      masterTapPreFader <= master_prefader_listen;
      vcaTapPrePan <= vca_prepan_listen;
      channelOnLamp <= next_channelOnLamp;
      checkLamp <= next_checkMode ? readData : '0;
      utilityLamp <= next_utilMode != UTIL_OFF;
      displayKind <= next_displayKind;
      displayValue <= next_displayValue;
    end
  end

  // checks on the registered behaviour
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  chk_input_takes_group: assert property (
    clkEnable && inNew |=> listenGroup == GRP_INPUT)
    else $error("input cue did not select input group");
  chk_group_revert: assert property (
    clkEnable && listenGroup == GRP_INPUT && inputCueLamp == '0 && !inNew && !vcaNew
      && !masterNew |=> listenGroup == $past(prevGroup))
    else $error("group did not revert after last input cue");
  chk_solo_mute: assert property (
    clkEnable && soloMode && inputCueLamp[0] && !inputCueLamp[1] |=> inputMute[1])
    else $error("uncued input not muted in solo");
  chk_solo_lamp_dark: assert property (
    clkEnable && !soloMode |=> !soloLamp)
    else $error("solo lamp lit outside solo mode");
  chk_cue_no_mute: assert property (
    clkEnable && !soloMode |=> inputMute == '0)
    else $error("mute applied in cue mode");
  chk_bus_follows_cue: assert property (
    clkEnable && soloMode && (soloSelLamp[SEL_STEREO] ^ soloSelPress[SEL_STEREO])
      |=> channelOnLamp[NUM_INPUT+STEREO_IDX] == $past(masterCueLamp[STEREO_IDX]))
    else $error("soloed bus on state does not follow cue");
  chk_tap_points: assert property (
    clkEnable |=> masterTapPreFader == $past(master_prefader_listen)
      && vcaTapPrePan == $past(vca_prepan_listen))
    else $error("tap point select not applied");
  chk_last_cue_clear: assert property (
    clkEnable && lastCueEdge |=> inputCueLamp == '0 && vcaCueLamp == '0
      && masterCueLamp == '0)
    else $error("latest-only change left cues engaged");
  chk_util_lamp_dark: assert property (
    clkEnable |=> utilityLamp == (utilMode != UTIL_OFF))
    else $error("utility lamp disagrees with mode");
  chk_entry_range: assert property (
    clkEnable && enterKey && entryActive && recallStage == RECALL_IDLE
      && directRecallKey == '0 && !recallKey && !storeKey && !checkKey && !digitPress
      && entryValue > SCENE_LAST |=> sceneNumber == $past(sceneNumber))
    else $error("out of range entry changed scene");
  chk_direct_load: assert property (
    clkEnable && recallStage == RECALL_IDLE && directRecallKey == 8'h01
      ##1 clkEnable [*2] |=> sceneNumber == SCENE_FIRST && onState == $past(readData))
    else $error("direct recall did not load scene one");

  cov_solo_mute: cover property (soloMode && |inputMute);
  cov_revert_vca: cover property (listenGroup == GRP_INPUT ##1 listenGroup == GRP_VCA);
  cov_recall: cover property (recallStage == RECALL_LOAD);

endmodule

`default_nettype wire

//--- panel_keys.sv
// front-panel model: turns bench cue key requests into cue presses one cycle later
`default_nettype none

module panel_keys
  import cue_solo_scene_pkg::*;
(
  // clock
  input wire logic sys_clk,
  // bench requests in, key presses out
  input wire logic [NUM_INPUT-1:0] cueReq,
  output logic [NUM_INPUT-1:0] inputCuePress
);
  timeunit 1ns;
  timeprecision 1ns;
  // a key contact follows the request one cycle later, so a request lasting one cycle gives one press
  always_ff @(posedge sys_clk)
    inputCuePress <= cueReq;
endmodule

`default_nettype wire

//--- cue_solo_scene_control_tb_top.sv
// self-checking bench for the cue, solo and scene control block
`default_nettype none

module cue_solo_scene_control_tb_top
  import cue_solo_scene_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // inputs given a value at time zero, plus some outputs and the panel presses
  logic sys_clk = 1'h0, reset = 1'h1, soloMode = 1'h0, lastCueSwitch = 1'h0;
  logic master_prefader_listen = 1'h0, vca_prepan_listen = 1'h0, utilityKey = 1'h0;
  logic recallKey = 1'h0, storeKey = 1'h0, enterKey = 1'h0, upKey = 1'h0;
  logic downKey = 1'h0, digitPress = 1'h0, checkKey = 1'h0;
  logic [3:0] digitValue = 4'h0;
  logic [DIRECT_COUNT-1:0] directRecallKey = '0;
  logic [NUM_ON-1:0] onEditPress = '0, channelOnLamp, checkLamp;
  logic [NUM_INPUT-1:0] cueReq = '0, inputCuePress, inputCueLamp, inputMute;
  // outputs, with the vca, master and solo select presses
  logic [NUM_VCA-1:0] vcaCueLamp, vcaCuePress = '0;
  logic [NUM_MASTER-1:0] masterCueLamp, masterCuePress = '0;
  logic [NUM_FEED-1:0] cueFeed;
  logic [NUM_SEL-1:0] soloSelLamp, soloSelPress = '0;
  logic soloLamp, masterTapPreFader, vcaTapPrePan, checkModeLamp, utilityLamp;
  listen_group_type listenGroup;
  display_kind_type displayKind;
  logic [7:0] displayValue;
  int miscompares = 0, compares = 0, n;
  // scene key rows: key 0 digit, 1 enter, 2 up, 3 down, then digit, then display
  typedef struct packed {int key; int val; logic [7:0] want;} row_type;
  row_type rows [17] = '{'{2, 0, 8'h02}, '{3, 0, 8'h01}, '{3, 0, 8'h01}, '{0, 5, 8'h05},
    '{1, 0, 8'h05}, '{0, 2, 8'h02}, '{0, 0, 8'h14}, '{0, 0, 8'hC8}, '{1, 0, 8'h05},
    '{0, 1, 8'h01}, '{0, 2, 8'h0C}, '{0, 8, 8'h80}, '{1, 0, 8'h80}, '{2, 0, 8'h80},
    '{3, 0, 8'h7F}, '{0, 1, 8'h01}, '{1, 0, 8'h01}};

  // short counts so flashing and the hold fit a short run
  cue_solo_scene_control #(.FLASH_CYCLES(4), .HOLD_CYCLES(8)) i_dut (
    .sys_clk, .reset, .clkEnable(1'h1), .inputCuePress, .vcaCuePress,
    .masterCuePress, .soloMode, .soloSelPress, .master_prefader_listen,
    .vca_prepan_listen, .lastCueSwitch, .utilityKey, .recallKey, .storeKey,
    .checkKey, .enterKey, .upKey, .downKey, .digitPress, .digitValue,
    .directRecallKey, .onEditPress, .inputCueLamp, .vcaCueLamp, .masterCueLamp,
    .listenGroup, .cueFeed, .inputMute, .soloLamp, .soloSelLamp, .masterTapPreFader,
    .vcaTapPrePan, .channelOnLamp, .checkModeLamp, .checkLamp, .utilityLamp,
    .displayKind, .displayValue);
  panel_keys i_panel (.sys_clk, .cueReq, .inputCuePress);

  // 20 MHz clock
  initial
    forever #25 sys_clk = ~sys_clk;

  // compare, count, report at once
  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    compares++;
    if (seen !== want)
    begin
      miscompares++;
      $display("BAD at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  // let n edges pass, then step off the edge so outputs have settled
  task automatic edges(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // one cue press through the panel: the model adds a cycle
  task automatic cue(input int idx);
    @(posedge sys_clk);
    cueReq <= NUM_INPUT'(1) << idx;
    @(posedge sys_clk);
    cueReq <= '0;
    edges(1);
  endtask
  // utility key held for len edges; the block acts on release
  task automatic press_util(input int len);
    @(posedge sys_clk);
    utilityKey <= 1'h1;
    repeat (len) @(posedge sys_clk);
    utilityKey <= 1'h0;
    edges(2);
  endtask
  task automatic give_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // a hang counts as a mismatch
  initial
  begin
    repeat (4000) @(posedge sys_clk);
    miscompares++;
    give_verdict();
  end

  initial
  begin
    repeat (4) @(posedge sys_clk);
    reset <= 1'h0;
    edges(0);
    check({utilityLamp, soloLamp, listenGroup, displayValue}, 12'h001);
    // scene number entry and stepping, one row per key
    foreach (rows[i])
    begin
      @(posedge sys_clk);
      digitPress <= rows[i].key == 4'h0;
      digitValue <= 4'(rows[i].val);
      enterKey <= rows[i].key == 4'h1;
      upKey <= rows[i].key == 4'h2;
      downKey <= rows[i].key == 4'h3;
      @(posedge sys_clk);
      {digitPress, enterKey, upKey, downKey} <= 4'h0;
      edges(0);
      check(displayValue, rows[i].want);
    end
    // store an on state, edit it away, recall it back
    @(posedge sys_clk);
    onEditPress <= 49'h1;
    @(posedge sys_clk);
    onEditPress <= '0;
    storeKey <= 1'h1;
    @(posedge sys_clk);
    storeKey <= 1'h0;
    onEditPress <= 49'h1;
    @(posedge sys_clk);
    onEditPress <= '0;
    recallKey <= 1'h1;
    #1 check(channelOnLamp[0], 1'h0);
    @(posedge sys_clk);
    recallKey <= 1'h0;
    edges(2);
    check(channelOnLamp[0], 1'h1);
    // step away from scene one so the direct key has something to change
    @(posedge sys_clk);
    upKey <= 1'h1;
    @(posedge sys_clk);
    upKey <= 1'h0;
    directRecallKey <= 8'h01;
    @(posedge sys_clk);
    directRecallKey <= 8'h00;
    edges(3);
    check(displayValue, 8'h01);
    @(posedge sys_clk);
    checkKey <= 1'h1;
    @(posedge sys_clk);
    checkKey <= 1'h0;
    edges(0);
    check({checkModeLamp, checkLamp}, {1'h1, 49'h1});
    // input cue takes the group and feeds phones, release reverts
    cue(3);
    check({inputCueLamp[3], listenGroup}, {1'h1, GRP_INPUT});
    edges(1);
    check({cueFeed[3], inputMute}, 25'h1000000);
    cue(3);
    edges(1);
    check({inputCueLamp[3], listenGroup}, {1'h0, GRP_MASTER});
    // a vca cue, then an input cue over it, then back to vca on release
    @(posedge sys_clk);
    vcaCuePress <= 8'h01;
    @(posedge sys_clk);
    vcaCuePress <= 8'h00;
    cue(3);
    cue(3);
    edges(1);
    check({vcaCueLamp[0], listenGroup}, {1'h1, GRP_VCA});
    // latest-only clears on both edges and keeps the newest press
    cue(5);
    @(posedge sys_clk);
    lastCueSwitch <= 1'h1;
    edges(2);
    check({vcaCueLamp, inputCueLamp}, '0);
    cue(7);
    cue(9);
    check(inputCueLamp, 24'h000200);
    @(posedge sys_clk);
    lastCueSwitch <= 1'h0;
    edges(2);
    check(inputCueLamp, '0);
    // solo mutes the others and the lamp flashes with half period 4
    @(posedge sys_clk);
    soloMode <= 1'h1;
    cue(0);
    edges(1);
    check(inputMute, 24'hFFFFFE);
    n = 0;
    repeat (16)
    begin
      edges(1);
      if (soloLamp === 1'h1)
        n++;
    end
    check(n, 8);
    // stereo solo select plus the stereo cue: its on lamp follows the cue
    @(posedge sys_clk);
    soloSelPress <= 4'h8;
    masterCuePress <= 25'h100;
    @(posedge sys_clk);
    {soloSelPress, masterCuePress} <= '0;
    edges(1);
    check({soloSelLamp, masterCueLamp[8], channelOnLamp[32], listenGroup}, 8'h8C);
    @(posedge sys_clk);
    soloMode <= 1'h0;
    edges(2);
    check({soloLamp, channelOnLamp[32]}, 2'h0);
    // listen tap selectors
    @(posedge sys_clk);
    master_prefader_listen <= 1'h1;
    vca_prepan_listen <= 1'h1;
    edges(2);
    check({masterTapPreFader, vcaTapPrePan}, 2'h3);
    // utility cycle and the long-hold exit
    press_util(1);
    check({displayKind, utilityLamp, displayValue}, {DISP_UTIL, 1'h1, 4'h0, UTIL_BATTERY});
    press_util(1);
    check(displayValue, {4'h0, UTIL_MEM_PROTECT});
    // store opens the parameter view, up then steps the parameter
    @(posedge sys_clk);
    storeKey <= 1'h1;
    @(posedge sys_clk);
    storeKey <= 1'h0;
    upKey <= 1'h1;
    @(posedge sys_clk);
    upKey <= 1'h0;
    edges(0);
    check({displayKind, displayValue}, {DISP_PARAM, 8'h01});
    press_util(10);
    check(utilityLamp, 1'h0);
    give_verdict();
  end
endmodule

`default_nettype wire
